// file: fad_add_if.sv
`timescale 1ns/100ps
// 16-bit add slice with carry, shared by every add and negate step
interface fad_add_if;
  logic [15:0] a;
  logic [15:0] b;
  logic cin;
  logic [15:0] sum;
  logic cout;
  modport user (output a, output b, output cin, input sum, input cout);
  modport unit (input a, input b, input cin, output sum, output cout);
endinterface : fad_add_if

// file: fad_adder.sv
`timescale 1ns/100ps
module fad_adder (
  fad_add_if.unit add // operand and result bundle
);

  // ----------------------------------------------------------------
  // word add with carry in and out
  // ----------------------------------------------------------------
  logic [16:0] wide;

  // one adder serves low and high halves on successive cycles
  always_comb begin
    wide = {1'b0, add.a} + {1'b0, add.b} + {16'h0000, add.cin};
    add.sum = wide[15:0];
    add.cout = wide[16];
  end

endmodule : fad_adder

// file: fad_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host bus request latch and pointer source
// ----------------------------------------------------------------
module fad_host_model #(
  parameter int SYNC_DIV = 4,
  parameter logic [15:0] SP_INIT = 16'h0400,
  parameter logic [15:0] PC_INIT = 16'h1000
) (
  input wire logic clock, // 40 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic pend, // request raised by a bus device
  input wire logic abort_strobe, // datapath gave way
  output logic bus_request, // latched request
  output logic [15:0] stack_ptr, // current stack pointer
  output logic [15:0] prog_ctr // current program counter
);
  int sync_cnt_r;
  logic bus_req_r;

  // latch on sync
  // a request lands only at master sync, so it can lag by SYNC_DIV
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_cnt_r <= 0;
      bus_req_r <= 1'b0;
    end else begin
      sync_cnt_r <= (sync_cnt_r == SYNC_DIV - 1) ? 0 : sync_cnt_r + 1;
      if (abort_strobe) begin
        bus_req_r <= 1'b0; // serviced once the op gives way
      end else if (pend && sync_cnt_r == SYNC_DIV - 1) begin
        bus_req_r <= 1'b1;
      end
    end
  end

  // pointers held still; the restart reloads them as they were
  assign bus_request = bus_req_r;
  assign stack_ptr = SP_INIT;
  assign prog_ctr = PC_INIT;
endmodule : fad_host_model

// file: fad_pkg.sv
package fad_pkg;

  // ----------------------------------------------------------------
  // word layout and limits
  // ----------------------------------------------------------------
  localparam int SIGN_BIT = 15;
  localparam int EXP_MSB = 14;
  localparam int EXP_LSB = 7;
  localparam int FRAC_MSB = 6;
  // 30 octal: a 24-bit mantissa cannot be shifted further
  localparam logic [7:0] ALIGN_LIMIT = 8'h18;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [15:0] SP_BACK = 16'h0006;
  localparam logic [15:0] PC_BACK = 16'h0002;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FAD_OP_ADD,
    FAD_OP_SUB,
    FAD_OP_MUL
  } fad_op_type;

  typedef enum logic [3:0] {
    S_IDLE,
    S_SWAP,
    S_DBL_LO,
    S_DBL_HI,
    S_SHIFT,
    S_ADD_LO,
    S_ADD_HI,
    S_FIX,
    S_NEG_LO,
    S_NEG_HI
  } fad_state_type;

  typedef struct packed {
    fad_state_type st;
    logic [15:0] p_hi;
    logic [15:0] p_lo;
    logic [15:0] s_hi;
    logic [15:0] s_lo;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [7:0] exp_r;
    logic [7:0] cnt;
    logic carry;
    logic eq;
    logic skip;
    logic neg;
    logic zero;
    logic zb;
    logic res_valid;
    logic abort;
    logic mul_done;
    logic mul_zero;
    logic [15:0] sp_out;
    logic [15:0] pc_out;
  } fad_regs_type;

  // signed 32-bit working form: hidden one, fetch guard bit, sign applied
  function automatic logic [31:0] fad_operand(input logic [15:0] hi,
                                              input logic [15:0] lo,
                                              input logic flip);
    logic [31:0] mag;
    logic hid;
    hid = |hi[EXP_MSB:EXP_LSB];
    mag = {7'h00, hid, hi[FRAC_MSB:0], lo, 1'b0};
    if (!hid) begin
      mag = 32'h0000_0000;
    end
    return (hi[SIGN_BIT] ^ flip) ? (~mag + 32'h0000_0001) : mag;
  endfunction : fad_operand

endpackage : fad_pkg

// file: fad_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %0t got %h want %h", $time, g, e); end end
module fad_tb_top;
  typedef struct packed {
    fad_pkg::fad_op_type op;
    logic [15:0] ah, al, bh, bl, rh, rl;
    logic [7:0] re;
    logic ng, zr;
  } fad_row_type;
  logic clock, rst_n, start, pend, bus_request;
  fad_pkg::fad_op_type op;
  logic [15:0] a_hi, a_lo, b_hi, b_lo, stack_ptr, prog_ctr;
  logic busy, result_valid, zero_status_flag, negative_status_flag;
  logic carry_status_flag, second_exponent_zero_flag, mul_done;
  logic mul_zero_path, abort_strobe, got;
  logic [15:0] result_hi, result_lo, stack_ptr_out, prog_ctr_out;
  logic [7:0] result_exp;
  int n_errors, samples_checked, i;
  fad_row_type r;
  // mul rows: re[1:0] holds both exponent-zero flags
  fad_row_type rows [12] = '{
    '{fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4080, 16'h0, 16'h0200,
      16'h0, 8'h81, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_SUB, 16'h4080, 16'h0, 16'h4080, 16'h0, 16'h0,
      16'h0, 8'h81, 1'b0, 1'b1},
    '{fad_pkg::FAD_OP_ADD, 16'h4100, 16'h0, 16'h4080, 16'h0, 16'h0180,
      16'h0, 8'h82, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_SUB, 16'h4100, 16'h0, 16'hC080, 16'h0, 16'h0180,
      16'h0, 8'h82, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'hC080, 16'h0, 16'h4200, 16'h0, 16'h00E0,
      16'h0, 8'h84, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'hC100, 16'h0, 16'h4080, 16'h0, 16'h0080,
      16'h0, 8'h82, 1'b1, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4D00, 16'h0, 16'h0100,
      16'h0, 8'h9A, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4C80, 16'h0, 16'h0100,
      16'h1, 8'h99, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'h4080, 16'hFFFF, 16'h4080, 16'hFFFF,
      16'h0203, 16'hFFFC, 8'h81, 1'b0, 1'b0},
    '{fad_pkg::FAD_OP_ADD, 16'h007F, 16'h1234, 16'h0, 16'h0, 16'h0,
      16'h0, 8'h00, 1'b0, 1'b1},
    '{fad_pkg::FAD_OP_MUL, 16'h0000, 16'h0, 16'hC100, 16'h0, 16'h0,
      16'h0, 8'h02, 1'b1, 1'b1},
    '{fad_pkg::FAD_OP_MUL, 16'hC080, 16'h0, 16'h007F, 16'h0, 16'h0,
      16'h0, 8'h01, 1'b1, 1'b1}};

  fad_top dut (.clock(clock), .rst_n(rst_n), .start(start), .op(op),
    .a_hi(a_hi), .a_lo(a_lo), .b_hi(b_hi), .b_lo(b_lo),
    .bus_request(bus_request), .stack_ptr(stack_ptr),
    .prog_ctr(prog_ctr), .busy(busy), .result_valid(result_valid),
    .result_hi(result_hi), .result_lo(result_lo),
    .result_exp(result_exp), .zero_status_flag(zero_status_flag),
    .negative_status_flag(negative_status_flag),
    .carry_status_flag(carry_status_flag),
    .second_exponent_zero_flag(second_exponent_zero_flag),
    .mul_done(mul_done), .mul_zero_path(mul_zero_path),
    .abort_strobe(abort_strobe), .stack_ptr_out(stack_ptr_out),
    .prog_ctr_out(prog_ctr_out));
  fad_host_model host (.clock(clock), .rst_n(rst_n), .pend(pend),
    .abort_strobe(abort_strobe), .bus_request(bus_request),
    .stack_ptr(stack_ptr), .prog_ctr(prog_ctr));

  // ----------------------------------------------------------------
  // clock, drivers, verdict
  // ----------------------------------------------------------------
  always #12.5 clock = ~clock;

  task automatic do_op(input fad_pkg::fad_op_type o,
                       input logic [15:0] ah, al, bh, bl);
    @(negedge clock);
    op = o;
    a_hi = ah;
    a_lo = al;
    b_hi = bh;
    b_lo = bl;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
  endtask : do_op

  // bounded wait; the longest add needs about 35 cycles
  task automatic wait_res();
    got = 1'b0;
    for (int k = 0; k < 60 && !got; k++) begin
      if (result_valid === 1'b1 || abort_strobe === 1'b1) got = 1'b1;
      else @(negedge clock);
    end
  endtask : wait_res

  task automatic test_done();
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    repeat (6000) @(posedge clock);
    n_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    start = 1'b0;
    pend = 1'b0;
    op = fad_pkg::FAD_OP_ADD;
    {a_hi, a_lo, b_hi, b_lo} = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    `CHK({busy, result_valid, mul_done, abort_strobe}, 4'h0);
    `CHK({result_hi, result_lo, stack_ptr_out}, 48'h0);
    // table of adds, subtracts and multiply entries
    for (i = 0; i < 12; i++) begin
      r = rows[i];
      do_op(r.op, r.ah, r.al, r.bh, r.bl);
      if (r.op == fad_pkg::FAD_OP_MUL) begin
        `CHK(mul_done, 1'b1);
        `CHK(negative_status_flag, r.ng);
        `CHK(mul_zero_path, r.zr);
        `CHK({zero_status_flag, second_exponent_zero_flag}, r.re[1:0]);
      end else begin
        wait_res();
        `CHK({result_valid, result_hi, result_lo}, {1'b1, r.rh, r.rl});
        `CHK(result_exp, r.re);
        `CHK(negative_status_flag, r.ng);
        `CHK(zero_status_flag, r.zr);
        @(negedge clock);
        `CHK({result_valid, busy}, 2'b00);
      end
    end
    // positive operands, both exponents nonzero: sign clear, no zero path
    do_op(fad_pkg::FAD_OP_MUL, 16'h4080, 16'h0, 16'h4100, 16'h0);
    `CHK({mul_done, negative_status_flag, mul_zero_path}, 3'b100);
    // equal magnitudes cancel; the high word add carries out
    do_op(fad_pkg::FAD_OP_SUB, 16'h4080, 16'h0, 16'h4080, 16'h0);
    wait_res();
    `CHK({carry_status_flag, zero_status_flag}, 2'b11);
    // start while busy is ignored; first operands win
    do_op(fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4C80, 16'h0);
    @(negedge clock);
    a_hi = 16'h4100;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    wait_res();
    `CHK({result_hi, result_lo}, 32'h0100_0001);
    // request latched before start: abort at first checkpoint
    pend = 1'b1;
    repeat (5) @(negedge clock);
    do_op(fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4080, 16'h0);
    wait_res();
    pend = 1'b0;
    `CHK({abort_strobe, result_valid}, 2'b10);
    `CHK(stack_ptr_out, stack_ptr - fad_pkg::SP_BACK);
    `CHK(prog_ctr_out, prog_ctr - fad_pkg::PC_BACK);
    @(negedge clock);
    `CHK(busy, 1'b0);
    // restart after servicing gives the full answer
    do_op(fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4080, 16'h0);
    wait_res();
    `CHK({result_valid, result_hi}, {1'b1, 16'h0200});
    // request arriving during the alignment loop
    do_op(fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4A80, 16'h0);
    // let the first checkpoint pass so the request lands in the loop
    repeat (4) @(negedge clock);
    pend = 1'b1;
    wait_res();
    pend = 1'b0;
    `CHK({abort_strobe, result_valid}, 2'b10);
    // reset in mid-run leaves nothing behind
    @(negedge clock);
    do_op(fad_pkg::FAD_OP_ADD, 16'h4080, 16'h0, 16'h4A80, 16'h0);
    rst_n = 1'b0;
    @(negedge clock);
    rst_n = 1'b1;
    `CHK({busy, result_valid, result_hi}, 18'h0);
    repeat (30) @(negedge clock);
    `CHK({result_valid, result_hi}, 17'h0);
    test_done();
  end
endmodule : fad_tb_top

// file: fad_top.sv
`timescale 1ns/100ps
// Functional notes
// RL1: larger first exponent swaps operands so larger one is primary
// RL2: swap keeps only larger exponent; smaller exponent discarded
// RL3: without swap the second exponent stays result exponent
// RL4: primary doubled low then high with carry, gaining guard bit
// RL5: doubled primary is 32 bits; upper bits are sign extension
// RL6: difference above 30 octal skips alignment; primary is result
// RL7: right alignment shifts replicate the sign bit
// RL8: equal exponents shift secondary left one, zero inserted
// RL9: secondary shifts right one less than exponent difference
// RL10: low add then high add with carry; sign to negative flag
// RL11: OR of high and low words gives zero test
// RL12: negative sum complemented low then high, zero retested
// RL13: positive result shifted right one dropping second guard bit
// RL14: checkpoints sense bus request and branch to abort
// RL15: abort backs stack pointer by 6 and program counter by 2
// RL16: host latches bus requests on data-cycle master sync
// RL17: multiply sign is XOR of high words, copied to negative flag
// RL18: multiply takes zero path if either exponent is zero
// RL19: subtract flips subtrahend sign, then follows add path
// RL20: hidden one only for nonzero exponent; zero exponent zeroes
// RL21: result, exponent and sign given with one-cycle valid strobe
module fad_top (
  input wire logic clock, // 40 MHz clock
  input wire logic rst_n, // sync reset, active low
  input wire logic start, // op request pulse
  input wire fad_pkg::fad_op_type op, // add, subtract or multiply
  input wire logic [15:0] a_hi, // first operand high word
  input wire logic [15:0] a_lo, // first operand low word
  input wire logic [15:0] b_hi, // second operand high word
  input wire logic [15:0] b_lo, // second operand low word
  input wire logic bus_request, // latched request from host
  input wire logic [15:0] stack_ptr, // current stack pointer
  input wire logic [15:0] prog_ctr, // current program counter
  output logic busy, // add/subtract in progress
  output logic result_valid, // one-cycle result strobe
  output logic [15:0] result_hi, // high result word
  output logic [15:0] result_lo, // low result word
  output logic [7:0] result_exp, // result exponent
  output logic zero_status_flag, // result or exponent zero
  output logic negative_status_flag, // sign of answer
  output logic carry_status_flag, // saved word carry
  output logic second_exponent_zero_flag, // second exponent zero
  output logic mul_done, // multiply entry strobe
  output logic mul_zero_path, // multiply yields zero
  output logic abort_strobe, // one-cycle abort pulse
  output logic [15:0] stack_ptr_out, // backed-up stack pointer
  output logic [15:0] prog_ctr_out // backed-up program counter
);

  // ----------------------------------------------------------------
  // state and adder
  // ----------------------------------------------------------------
  fad_pkg::fad_regs_type q;
  fad_pkg::fad_regs_type d;
  fad_add_if add_bus ();

  fad_adder u_adder (
    .add(add_bus.unit)
  );

  // adder operand select by step
  always_comb begin
    add_bus.a = 16'h0000;
    add_bus.b = 16'h0000;
    add_bus.cin = 1'b0;
    unique case (q.st)
      fad_pkg::S_DBL_LO: begin
        add_bus.a = q.p_lo;
        add_bus.b = q.p_lo;
      end
      fad_pkg::S_DBL_HI: begin
        add_bus.a = q.p_hi;
        add_bus.b = q.p_hi;
        add_bus.cin = q.carry;
      end
      fad_pkg::S_ADD_LO: begin
        add_bus.a = q.p_lo;
        add_bus.b = q.s_lo;
      end
      fad_pkg::S_ADD_HI: begin
        add_bus.a = q.p_hi;
        add_bus.b = q.s_hi;
        add_bus.cin = q.carry;
      end
      fad_pkg::S_NEG_LO: begin
        add_bus.a = ~q.p_lo;
        add_bus.cin = 1'b1;
      end
      fad_pkg::S_NEG_HI: begin
        add_bus.a = ~q.p_hi;
        add_bus.cin = q.carry;
      end
      default: begin
        add_bus.cin = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic [31:0] opa;
  logic [31:0] opb;
  logic [31:0] sec;
  logic go_abort;

  // sequencer: one step per clock
  always_comb begin
    d = q;
    d.res_valid = 1'b0;
    d.abort = 1'b0;
    d.mul_done = 1'b0;
    go_abort = 1'b0;
    sec = {q.s_hi, q.s_lo};
    // RL20 hidden one
    opa = fad_pkg::fad_operand(a_hi, a_lo, 1'b0);
    // RL19 subtrahend sign flip
    opb = fad_pkg::fad_operand(b_hi, b_lo, op == fad_pkg::FAD_OP_SUB);
    unique case (q.st)
      fad_pkg::S_IDLE: begin
        if (start) begin
          d.ea = a_hi[fad_pkg::EXP_MSB:fad_pkg::EXP_LSB];
          d.eb = b_hi[fad_pkg::EXP_MSB:fad_pkg::EXP_LSB];
          d.zero = ~|a_hi[fad_pkg::EXP_MSB:fad_pkg::EXP_LSB];
          d.zb = ~|b_hi[fad_pkg::EXP_MSB:fad_pkg::EXP_LSB];
          if (op == fad_pkg::FAD_OP_MUL) begin
            // RL17 multiply sign
            d.neg = a_hi[fad_pkg::SIGN_BIT] ^ b_hi[fad_pkg::SIGN_BIT];
            // RL18 zero operand test
            d.mul_zero = d.zero | d.zb;
            d.mul_done = 1'b1;
          end else begin
            {d.p_hi, d.p_lo} = opb; // second operand leads by default
            {d.s_hi, d.s_lo} = opa;
            d.st = fad_pkg::S_SWAP;
          end
        end
      end
      fad_pkg::S_SWAP: begin
        d.eq = q.ea == q.eb;
        if (q.ea > q.eb) begin
          // RL1 operand exchange
          {d.p_hi, d.p_lo} = {q.s_hi, q.s_lo};
          {d.s_hi, d.s_lo} = {q.p_hi, q.p_lo};
          // RL2 keep larger exponent
          d.exp_r = q.ea;
          d.cnt = q.ea - q.eb;
        end else begin
          // RL3 second exponent stays
          d.exp_r = q.eb;
          d.cnt = q.eb - q.ea;
        end
        d.st = fad_pkg::S_DBL_LO;
      end
      fad_pkg::S_DBL_LO: begin
        // RL4 double low word
        d.p_lo = add_bus.sum;
        d.carry = add_bus.cout;
        // RL6 range test
        d.skip = q.cnt > fad_pkg::ALIGN_LIMIT;
        d.st = fad_pkg::S_DBL_HI;
      end
      fad_pkg::S_DBL_HI: begin
        // RL5 high word doubled with carry, sign kept as extension
        d.p_hi = add_bus.sum;
        d.carry = add_bus.cout;
        if (!q.eq) begin
          d.cnt = q.cnt - fad_pkg::CNT_ONE;
        end
        // RL14 checkpoint
        if (bus_request) begin
          go_abort = 1'b1;
        end else if (q.skip) begin
          // RL6 primary sign is the answer sign
          d.neg = q.p_hi[fad_pkg::SIGN_BIT];
          d.st = fad_pkg::S_FIX;
        end else if (q.eq) begin
          // RL8 equal exponents
          {d.s_hi, d.s_lo} = {sec[30:0], 1'b0};
          d.st = fad_pkg::S_ADD_LO;
        end else if (q.cnt == fad_pkg::CNT_ONE) begin
          // RL9 difference of one: no shift
          d.st = fad_pkg::S_ADD_LO;
        end else begin
          d.st = fad_pkg::S_SHIFT;
        end
      end
      fad_pkg::S_SHIFT: begin
        // RL14 checked on every pass
        if (bus_request) begin
          go_abort = 1'b1;
        end else begin
          // RL7 sign replicated
          {d.s_hi, d.s_lo} = {sec[31], sec[31:1]};
          // RL9 passes one fewer than difference
          d.cnt = q.cnt - fad_pkg::CNT_ONE;
          if (q.cnt == fad_pkg::CNT_ONE) begin
            d.st = fad_pkg::S_ADD_LO;
          end
        end
      end
      fad_pkg::S_ADD_LO: begin
        // RL10 low words first
        d.p_lo = add_bus.sum;
        d.carry = add_bus.cout;
        d.st = fad_pkg::S_ADD_HI;
      end
      fad_pkg::S_ADD_HI: begin
        // RL10 high words with carry
        d.p_hi = add_bus.sum;
        d.carry = add_bus.cout;
        d.neg = add_bus.sum[fad_pkg::SIGN_BIT];
        d.st = fad_pkg::S_FIX;
      end
      fad_pkg::S_FIX: begin
        // RL11 zero test across both words
        d.zero = ~|(q.p_hi | q.p_lo);
        if (q.p_hi[fad_pkg::SIGN_BIT]) begin
          d.st = fad_pkg::S_NEG_LO;
        end else begin
          // RL13 drop second guard bit
          {d.p_hi, d.p_lo} = {1'b0, q.p_hi, q.p_lo[15:1]};
          // RL21 result strobe
          d.res_valid = 1'b1;
          d.st = fad_pkg::S_IDLE;
        end
      end
      fad_pkg::S_NEG_LO: begin
        // RL12 complement low word
        d.p_lo = add_bus.sum;
        d.carry = add_bus.cout;
        d.st = fad_pkg::S_NEG_HI;
      end
      fad_pkg::S_NEG_HI: begin
        // RL12 complement high word, then retest
        d.p_hi = add_bus.sum;
        d.st = fad_pkg::S_FIX;
      end
      default: begin
        d.st = fad_pkg::S_IDLE;
      end
    endcase
    // RL15 restart pointers
    if (go_abort) begin
      d.abort = 1'b1;
      d.sp_out = stack_ptr - fad_pkg::SP_BACK;
      d.pc_out = prog_ctr - fad_pkg::PC_BACK;
      d.st = fad_pkg::S_IDLE;
    end
  end

  // single state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all data straight from flops; busy is a state decode
  assign busy = q.st != fad_pkg::S_IDLE;
  assign result_valid = q.res_valid;
  assign result_hi = q.p_hi;
  assign result_lo = q.p_lo;
  assign result_exp = q.exp_r;
  assign zero_status_flag = q.zero;
  assign negative_status_flag = q.neg;
  assign carry_status_flag = q.carry;
  assign second_exponent_zero_flag = q.zb;
  assign mul_done = q.mul_done;
  assign mul_zero_path = q.mul_zero;
  assign abort_strobe = q.abort;
  assign stack_ptr_out = q.sp_out;
  assign prog_ctr_out = q.pc_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  swap_exp_max_a: assert property ( // RL2
    q.st == fad_pkg::S_SWAP |=> q.exp_r == (q.ea > q.eb ? q.ea : q.eb))
    else $error("result exponent is not the larger one");
  swap_order_a: assert property ( // RL1
    q.st == fad_pkg::S_SWAP && q.ea > q.eb |=>
      {q.p_hi, q.p_lo} == $past({q.s_hi, q.s_lo}))
    else $error("operands not exchanged");
  skip_range_a: assert property ( // RL6
    q.st == fad_pkg::S_DBL_LO |=>
      q.skip == ($past(q.cnt) > fad_pkg::ALIGN_LIMIT))
    else $error("range skip decision wrong");
  shift_sign_a: assert property ( // RL7
    q.st == fad_pkg::S_SHIFT && !bus_request |=>
      q.s_hi[15] == $past(q.s_hi[15]) && q.s_hi[14] == $past(q.s_hi[15]))
    else $error("alignment shift lost the sign");
  neg_flag_a: assert property ( // RL10
    q.st == fad_pkg::S_ADD_HI |=> q.neg == q.p_hi[15])
    else $error("negative flag not the sum sign");
  result_pos_a: assert property ( // RL13
    q.res_valid |-> !q.p_hi[15] && $past(q.st) == fad_pkg::S_FIX)
    else $error("result not positive");
  valid_pulse_a: assert property ( // RL21
    q.res_valid |=> !q.res_valid)
    else $error("valid longer than one cycle");
  check_abort_a: assert property ( // RL14
    q.st == fad_pkg::S_SHIFT && bus_request |=> q.abort && !busy)
    else $error("bus request not honoured");
  abort_ptr_a: assert property ( // RL15
    q.abort |-> q.sp_out == $past(stack_ptr) - fad_pkg::SP_BACK &&
      q.pc_out == $past(prog_ctr) - fad_pkg::PC_BACK)
    else $error("abort pointers wrong");
  mul_sign_a: assert property ( // RL17
    !busy && start && op == fad_pkg::FAD_OP_MUL |=>
      q.mul_done && q.neg == $past(a_hi[15] ^ b_hi[15]))
    else $error("multiply sign wrong");
  mul_zero_a: assert property ( // RL18
    q.mul_done |-> q.mul_zero == (q.zero || q.zb))
    else $error("multiply zero path wrong");
  eq_shift_a: assert property ( // RL8
    q.st == fad_pkg::S_DBL_HI && q.eq && !bus_request |=>
      {q.s_hi, q.s_lo} == {$past(q.s_hi[14:0]), $past(q.s_lo), 1'b0})
    else $error("equal exponents not aligned");
  skip_sign_a: assert property ( // RL6
    q.st == fad_pkg::S_DBL_HI && q.skip && !bus_request |=>
      q.st == fad_pkg::S_FIX && q.neg == $past(q.p_hi[15]))
    else $error("skipped result sign wrong");
  zero_test_a: assert property ( // RL11
    q.st == fad_pkg::S_FIX |=>
      q.zero == ($past(q.p_hi | q.p_lo) == 16'h0000))
    else $error("zero test wrong");
  neg_fix_a: assert property ( // RL12
    q.st == fad_pkg::S_FIX && q.p_hi[15] |=>
      q.st == fad_pkg::S_NEG_LO ##1 q.st == fad_pkg::S_NEG_HI ##1
      q.st == fad_pkg::S_FIX && !q.p_hi[15])
    else $error("negative sum not complemented");

  add_done_c: cover property (q.res_valid && q.neg);
  abort_seen_c: cover property (q.abort);
  skip_path_c: cover property (q.st == fad_pkg::S_FIX && q.skip);
  mul_zero_c: cover property (q.mul_done && q.mul_zero);

endmodule : fad_top
